// File: shared/bcl_pkg.sv
// bcl_pkg: types and constants of the branch condition and loop unit.
// assumes one core clock; register offsets are byte addresses on AHB-Lite.
package bcl_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0]  BCL_OFS_CTRL      = 8'h00;
	localparam logic [7:0]  BCL_OFS_STATUS    = 8'h04;
	localparam logic [7:0]  BCL_OFS_TARGET    = 8'h08;
	localparam logic [7:0]  BCL_OFS_TAKEN_CNT = 8'h0c;
	localparam int          BCL_CTRL_EN_BIT   = 0;
	localparam int          BCL_STAT_TKN_BIT  = 0;
	localparam int          BCL_STAT_LOOP_BIT = 1;
	localparam logic        BCL_CTRL_EN_RST   = 1'b1;
	localparam logic [31:0] BCL_WORD_ZERO     = 32'h0000_0000;
	localparam logic [31:0] BCL_WRAP_32       = 32'hffff_ffff;
	localparam logic [1:0]  BCL_RESP_OKAY     = 2'h0;

	// ------------------------------------------------------------
	// condition codes, one code per alias pair
	// ------------------------------------------------------------
	localparam logic [3:0] BCL_CC_O  = 4'h0;
	localparam logic [3:0] BCL_CC_NO = 4'h1;
	localparam logic [3:0] BCL_CC_B  = 4'h2;
	localparam logic [3:0] BCL_CC_AE = 4'h3;
	localparam logic [3:0] BCL_CC_E  = 4'h4;
	localparam logic [3:0] BCL_CC_NE = 4'h5;
	localparam logic [3:0] BCL_CC_BE = 4'h6;
	localparam logic [3:0] BCL_CC_A  = 4'h7;
	localparam logic [3:0] BCL_CC_S  = 4'h8;
	localparam logic [3:0] BCL_CC_NS = 4'h9;
	localparam logic [3:0] BCL_CC_P  = 4'ha;
	localparam logic [3:0] BCL_CC_NP = 4'hb;
	localparam logic [3:0] BCL_CC_L  = 4'hc;
	localparam logic [3:0] BCL_CC_GE = 4'hd;
	localparam logic [3:0] BCL_CC_LE = 4'he;
	localparam logic [3:0] BCL_CC_G  = 4'hf;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		BCL_OP_JCC,
		BCL_OP_COUNT_ZERO,
		BCL_OP_LOOP,
		BCL_OP_LOOP_EQ,
		BCL_OP_LOOP_NE
	} bcl_op_t;

	typedef struct packed {
		logic carry_flag;
		logic parity_flag;
		logic zero_flag;
		logic sign_flag;
		logic overflow_flag;
	} bcl_flags_t;

	typedef struct packed {
		bcl_op_t     op;
		logic [3:0]  cc;
		logic        addr16;
		bcl_flags_t  flags;
		logic [31:0] ip;
		logic [31:0] disp;
		logic [31:0] count;
	} bcl_req_t;

	typedef struct packed {
		logic        taken;
		logic [31:0] target;
		logic [31:0] fetch_ip;
		logic        count_wr;
		logic [31:0] count;
	} bcl_res_t;

endpackage : bcl_pkg

// File: hdl/bcl_branch_unit.sv
// bcl_branch_unit: resolves conditional near branches, count-zero
// branches and counted loops, one request per cycle, result next cycle.
// assumes the decoder supplies the pointer of the following instruction,
// the current flags and count, and writes back count when told to.
//
// Summary of operation
// - condition true redirects fetch to target, else next instruction
// - taken branch saves no return address
// - target is instruction pointer plus signed displacement
// - only near relative targets, no code segment change
// - above, below-or-equal, equal and not-equal from carry and zero
// - above-or-equal, below, carry, no carry, parity even and odd
// - greater and less-or-equal from sign xor overflow, or zero
// - greater-or-equal, less, overflow, sign and their negations
// - conditions use only the five status flags, except count-zero
// - alias condition names share one condition code
// - 32-bit count-zero branch tests whole count, leaves it unchanged
// - 16-bit count-zero branch tests only the low count half
// - loops decrement count first, low half when address size is 16
// - plain loop jumps while decremented count is non-zero
// - loop target is signed offset from instruction pointer
// - zero count on entry wraps to all ones
// - loop-while-equal jumps on non-zero count and zero flag set
// - loop-while-unequal ends the loop when zero flag is set
// - equal and zero loop variants are one operation
`timescale 1ns/1ps
`default_nettype none

module bcl_branch_unit (
	input  wire logic              CORE_CLK,
	input  wire logic              RST,
	input  wire logic              REQ_VALID,
	input  wire bcl_pkg::bcl_req_t REQ,
	output var  logic              RES_VALID,
	output var  bcl_pkg::bcl_res_t RES,
	input  wire logic              HSEL,
	input  wire logic [31:0]       HADDR,
	input  wire logic [1:0]        HTRANS,
	input  wire logic              HWRITE,
	input  wire logic [2:0]        HSIZE,
	input  wire logic [31:0]       HWDATA,
	input  wire logic              HREADY,
	output var  logic              HREADYOUT,
	output var  logic              HRESP,
	output var  logic [31:0]       HRDATA
);
	import bcl_pkg::*;

	// ------------------------------------------------------------
	// condition evaluation
	// ------------------------------------------------------------
	function automatic logic cond_met(input logic [3:0] cc,
	                                  input bcl_flags_t f);
		logic lt;
		lt = f.sign_flag ^ f.overflow_flag;
		unique case (cc)
			BCL_CC_O:  return f.overflow_flag;
			BCL_CC_NO: return !f.overflow_flag;
			BCL_CC_B:  return f.carry_flag;
			BCL_CC_AE: return !f.carry_flag;
			BCL_CC_E:  return f.zero_flag;
			BCL_CC_NE: return !f.zero_flag;
			BCL_CC_BE: return f.carry_flag | f.zero_flag;
			BCL_CC_A:  return !(f.carry_flag | f.zero_flag);
			BCL_CC_S:  return f.sign_flag;
			BCL_CC_NS: return !f.sign_flag;
			BCL_CC_P:  return f.parity_flag;
			BCL_CC_NP: return !f.parity_flag;
			BCL_CC_L:  return lt;
			BCL_CC_GE: return !lt;
			BCL_CC_LE: return lt | f.zero_flag;
			BCL_CC_G:  return !(lt | f.zero_flag);
		endcase
	endfunction : cond_met

	function automatic logic count_zero(input logic [31:0] c,
	                                    input logic a16);
		return a16 ? (c[15:0] == BCL_WORD_ZERO[15:0])
		           : (c == BCL_WORD_ZERO);
	endfunction : count_zero

	// the upper half survives a 16-bit decrement untouched
	function automatic logic [31:0] dec_count(input logic [31:0] c,
	                                          input logic a16);
		logic [15:0] lo;
		lo = 16'(c[15:0] - 16'h0001);
		return a16 ? {c[31:16], lo} : 32'(c - 32'h0000_0001);
	endfunction : dec_count

	// ------------------------------------------------------------
	// decision path
	// ------------------------------------------------------------
	logic        en_q;
	logic        res_valid_q;
	bcl_res_t    res_q;
	bcl_res_t    res_d;
	logic        accept;
	logic        is_loop;
	logic        dec_nz;
	logic        taken_c;
	logic [31:0] cnt_dec;
	logic [31:0] target_c;

	assign accept   = REQ_VALID && en_q;
	assign is_loop  = (REQ.op == BCL_OP_LOOP) || (REQ.op == BCL_OP_LOOP_EQ)
	               || (REQ.op == BCL_OP_LOOP_NE);
	assign cnt_dec  = dec_count(REQ.count, REQ.addr16);
	assign dec_nz   = !count_zero(cnt_dec, REQ.addr16);
	// near only: no segment leaves this unit, so no far transfer exists
	assign target_c = 32'(REQ.ip + REQ.disp);

	always_comb begin
		unique case (REQ.op)
			BCL_OP_JCC:        taken_c = cond_met(REQ.cc, REQ.flags);
			BCL_OP_COUNT_ZERO: taken_c = count_zero(REQ.count,
			                                        REQ.addr16);
			BCL_OP_LOOP:       taken_c = dec_nz;
			BCL_OP_LOOP_EQ:    taken_c = dec_nz && REQ.flags.zero_flag;
			BCL_OP_LOOP_NE:    taken_c = dec_nz && !REQ.flags.zero_flag;
			default:           taken_c = 1'b0;
		endcase
	end

	// no stack or return-address output: a taken branch saves nothing
	assign res_d.taken    = taken_c;
	assign res_d.target   = target_c;
	assign res_d.fetch_ip = taken_c ? target_c : REQ.ip;
	assign res_d.count_wr = is_loop;
	assign res_d.count    = is_loop ? cnt_dec : REQ.count;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			res_valid_q <= 1'b0;
			res_q       <= '0;
		end else begin
			res_valid_q <= accept;
			if (accept) begin
				res_q <= res_d;
			end
		end
	end

	assign RES_VALID = res_valid_q;
	assign RES       = res_q;

	// ------------------------------------------------------------
	// register file on AHB-Lite, zero wait states
	// ------------------------------------------------------------
	logic        wr_q;
	logic [7:0]  waddr_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [31:0] tkn_cnt_q;
	logic [31:0] tkn_cnt_d;
	logic        ahb_go;
	logic        cnt_clr;
	logic [31:0] status_w;
	logic [31:0] ctrl_w;

	assign ahb_go   = HSEL && HTRANS[1] && HREADY;
	assign cnt_clr  = wr_q && (waddr_q == BCL_OFS_TAKEN_CNT);
	assign status_w = {30'h0, res_q.count_wr, res_q.taken};
	assign ctrl_w   = {31'h0, en_q};

	// increment after the clear, so a branch in the clearing cycle counts
	assign tkn_cnt_d = 32'((cnt_clr ? BCL_WORD_ZERO : tkn_cnt_q)
	                 + {31'h0, accept && taken_c});

	always_comb begin
		rdata_d = BCL_WORD_ZERO;
		if (ahb_go && !HWRITE) begin
			unique case (HADDR[7:0])
				BCL_OFS_CTRL:      rdata_d = ctrl_w;
				BCL_OFS_STATUS:    rdata_d = status_w;
				BCL_OFS_TARGET:    rdata_d = res_q.target;
				BCL_OFS_TAKEN_CNT: rdata_d = tkn_cnt_q;
				default:           rdata_d = BCL_WORD_ZERO;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			wr_q      <= 1'b0;
			waddr_q   <= 8'h00;
			rdata_q   <= BCL_WORD_ZERO;
			en_q      <= BCL_CTRL_EN_RST;
			tkn_cnt_q <= BCL_WORD_ZERO;
		end else begin
			wr_q      <= ahb_go && HWRITE;
			waddr_q   <= HADDR[7:0];
			rdata_q   <= rdata_d;
			tkn_cnt_q <= tkn_cnt_d;
			if (wr_q && (waddr_q == BCL_OFS_CTRL)) begin
				en_q <= HWDATA[BCL_CTRL_EN_BIT];
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			HREADYOUT <= 1'b1;
			HRESP     <= BCL_RESP_OKAY[0];
		end else begin
			HREADYOUT <= 1'b1;
			HRESP     <= BCL_RESP_OKAY[0];
		end
	end

	assign HRDATA = rdata_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	sequence s_op(bcl_op_t o);
		accept && (REQ.op == o);
	endsequence

	sequence s_jcc(logic [3:0] c);
		accept && (REQ.op == BCL_OP_JCC) && (REQ.cc == c);
	endsequence

	sequence s_loop(logic a16);
		accept && is_loop && (REQ.addr16 == a16);
	endsequence

	property p_fetch;
		accept |=> RES_VALID && (RES.fetch_ip ==
		           (RES.taken ? $past(REQ.ip) + $past(REQ.disp)
		                      : $past(REQ.ip)));
	endproperty
	a_fetch: assert property (p_fetch)
		else $error("fetch pointer wrong");

	property p_target;
		accept |=> RES.target == $past(REQ.ip) + $past(REQ.disp);
	endproperty
	a_target: assert property (p_target)
		else $error("branch target wrong");

	property p_above;
		s_jcc(BCL_CC_A) |=> RES.taken ==
		    !($past(REQ.flags.carry_flag) | $past(REQ.flags.zero_flag));
	endproperty
	a_above: assert property (p_above)
		else $error("above condition wrong");

	property p_parity;
		s_jcc(BCL_CC_P) |=> RES.taken == $past(REQ.flags.parity_flag);
	endproperty
	a_parity: assert property (p_parity)
		else $error("parity condition wrong");

	property p_greater;
		s_jcc(BCL_CC_G) |=> RES.taken == !(($past(REQ.flags.sign_flag)
		    ^ $past(REQ.flags.overflow_flag)) | $past(REQ.flags.zero_flag));
	endproperty
	a_greater: assert property (p_greater)
		else $error("greater condition wrong");

	property p_less;
		s_jcc(BCL_CC_L) |=> RES.taken == ($past(REQ.flags.sign_flag)
		    ^ $past(REQ.flags.overflow_flag));
	endproperty
	a_less: assert property (p_less)
		else $error("less condition wrong");

	property p_cz;
		s_op(BCL_OP_COUNT_ZERO) |=> !RES.count_wr
		    && (RES.count == $past(REQ.count))
		    && (RES.taken == ($past(REQ.addr16)
		        ? ($past(REQ.count[15:0]) == 16'h0000)
		        : ($past(REQ.count) == BCL_WORD_ZERO)));
	endproperty
	a_cz: assert property (p_cz)
		else $error("count-zero branch wrong");

	property p_wrap;
		s_op(BCL_OP_LOOP) ##0 (!REQ.addr16 && REQ.count == BCL_WORD_ZERO)
		    |=> RES.count_wr && RES.taken && (RES.count == BCL_WRAP_32);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("loop count did not wrap");

	property p_loop;
		s_op(BCL_OP_LOOP) |=> RES.count_wr
		    && (RES.taken == !($past(REQ.addr16)
		        ? (RES.count[15:0] == 16'h0000)
		        : (RES.count == BCL_WORD_ZERO)));
	endproperty
	a_loop: assert property (p_loop)
		else $error("plain loop decision wrong");

	property p_loop_eq;
		s_op(BCL_OP_LOOP_EQ) ##0 !REQ.flags.zero_flag |=> !RES.taken;
	endproperty
	a_loop_eq: assert property (p_loop_eq)
		else $error("loop-while-equal taken with zero flag clear");

	property p_loop_ne;
		s_op(BCL_OP_LOOP_NE) ##0 REQ.flags.zero_flag |=> !RES.taken;
	endproperty
	a_loop_ne: assert property (p_loop_ne)
		else $error("loop-while-unequal taken with zero flag set");

	property p_disabled;
		!en_q |=> !RES_VALID;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("result while disabled");

	property p_pulse;
		!accept |=> !RES_VALID;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("result without a request");

	property p_jcc_count;
		s_op(BCL_OP_JCC) |=> !RES.count_wr
		    && (RES.count == $past(REQ.count));
	endproperty
	a_jcc_count: assert property (p_jcc_count)
		else $error("conditional branch touched the count");

	property p_loop16;
		s_loop(1'b1) |=> RES.count_wr
		    && (RES.count[31:16] == $past(REQ.count[31:16]))
		    && (RES.count[15:0] == 16'($past(REQ.count[15:0]) - 16'h0001));
	endproperty
	a_loop16: assert property (p_loop16)
		else $error("16-bit loop count wrong");

	property p_loop32;
		s_loop(1'b0) |=> RES.count_wr
		    && (RES.count == 32'($past(REQ.count) - 32'h0000_0001));
	endproperty
	a_loop32: assert property (p_loop32)
		else $error("32-bit loop count wrong");

	property p_eq_run;
		s_op(BCL_OP_LOOP_EQ) ##0 REQ.flags.zero_flag |=> RES.taken ==
		    ($past(REQ.addr16) ? (RES.count[15:0] != 16'h0000)
		                       : (RES.count != BCL_WORD_ZERO));
	endproperty
	a_eq_run: assert property (p_eq_run)
		else $error("loop-while-equal decision wrong");

	property p_ne_run;
		s_op(BCL_OP_LOOP_NE) ##0 !REQ.flags.zero_flag |=> RES.taken ==
		    ($past(REQ.addr16) ? (RES.count[15:0] != 16'h0000)
		                       : (RES.count != BCL_WORD_ZERO));
	endproperty
	a_ne_run: assert property (p_ne_run)
		else $error("loop-while-unequal decision wrong");

	property p_less_eq;
		s_jcc(BCL_CC_LE) |=> RES.taken == (($past(REQ.flags.sign_flag)
		    ^ $past(REQ.flags.overflow_flag)) | $past(REQ.flags.zero_flag));
	endproperty
	a_less_eq: assert property (p_less_eq)
		else $error("less-or-equal condition wrong");

	property p_ge;
		s_jcc(BCL_CC_GE) |=> RES.taken == !($past(REQ.flags.sign_flag)
		    ^ $past(REQ.flags.overflow_flag));
	endproperty
	a_ge: assert property (p_ge)
		else $error("greater-or-equal condition wrong");

	// set wins: a branch taken in the clearing cycle still counts
	property p_clear;
		cnt_clr |=> tkn_cnt_q == {31'h0, $past(accept && taken_c)};
	endproperty
	a_clear: assert property (p_clear)
		else $error("taken count not cleared");

	property p_enable;
		wr_q && (waddr_q == BCL_OFS_CTRL)
		    |=> en_q == $past(HWDATA[BCL_CTRL_EN_BIT]);
	endproperty
	a_enable: assert property (p_enable)
		else $error("enable bit not written");

endmodule : bcl_branch_unit

`default_nettype wire

// File: verification/bcl_core_model.sv
// bcl_core_model: decoder and flag core facing the branch unit.
// assumes the bench calls send() right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module bcl_core_model (
	input  wire logic              CORE_CLK,
	input  wire logic              RST,
	input  wire logic              RES_VALID,
	input  wire bcl_pkg::bcl_res_t RES,
	output var  logic              REQ_VALID,
	output var  bcl_pkg::bcl_req_t REQ
);
	import bcl_pkg::*;
	logic [31:0] count_q;
	logic        seen_v;
	bcl_res_t    seen;
	initial {REQ_VALID, REQ} = '0;
	// the core owns the count register and takes the unit's write-back
	always @(posedge CORE_CLK) begin
		if (RST)
			count_q <= 32'h0000_0000;
		else if (RES_VALID && RES.count_wr)
			count_q <= RES.count;
	end
	// idle lines carry the inverse, so a stale request never looks live
	task automatic send(input bcl_req_t r);
		REQ_VALID <= 1'b1;
		REQ <= r;
		@(posedge CORE_CLK);
		REQ_VALID <= 1'b0;
		REQ <= bcl_req_t'(~r);
		#1;
		seen_v = RES_VALID;
		seen = RES;
		@(posedge CORE_CLK);
	endtask : send
endmodule : bcl_core_model
`default_nettype wire

// File: verification/branch_condition_loop_unit_tb.sv
// branch_condition_loop_unit_tb: self-checking bench of bcl_branch_unit.
// assumes bcl_core_model issues requests; the bench is the bus master.
`timescale 1ns/1ps
`default_nettype none
module branch_condition_loop_unit_tb;
	import bcl_pkg::*;
	logic             CORE_CLK, RST, HSEL, HWRITE, et, nz;
	logic [1:0]       HTRANS;
	logic [2:0]       HSIZE;
	logic [31:0]      HADDR, HWDATA, rd, cnt, dec;
	wire logic        REQ_VALID, RES_VALID, HREADYOUT, HRESP;
	wire logic [31:0] HRDATA;
	wire bcl_req_t    REQ;
	wire bcl_res_t    RES;
	bcl_req_t         r;
	int               num_errors, checked, ntaken, i, k, z, a, c;
	logic             cz_a [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	logic             cz_t [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
	logic [31:0]      cz_c [5] = '{32'h0, 32'h1_0000, 32'h1_0000, 32'h1,
		32'hffff_ffff};

	bcl_branch_unit bcl_branch_unit_inst (
		.CORE_CLK(CORE_CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ(REQ),
		.RES_VALID(RES_VALID), .RES(RES), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.HRDATA(HRDATA));
	bcl_core_model bcl_core_model_inst (
		.CORE_CLK(CORE_CLK), .RST(RST), .RES_VALID(RES_VALID), .RES(RES),
		.REQ_VALID(REQ_VALID), .REQ(REQ));

	always #20 CORE_CLK = ~CORE_CLK;

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] e);
		checked++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, s);
			num_errors++;
		end
	endtask : chk

	task automatic bus(input logic w, input logic [31:0] ad,
		input logic [31:0] d, output logic [31:0] q);
		HSEL <= 1'b1;
		HADDR <= ad;
		HWRITE <= w;
		HTRANS <= 2'h2;
		do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
		q = HRDATA;
		chk("response", 32'(HRESP), 32'(BCL_RESP_OKAY));
	endtask : bus

	// sends r and compares the whole result against the expectation
	task automatic run(input logic t, input logic [31:0] cn, input logic wr);
		bcl_res_t s;
		bcl_core_model_inst.send(r);
		s = bcl_core_model_inst.seen;
		chk("valid", 32'(bcl_core_model_inst.seen_v), 32'h1);
		chk("taken", 32'(s.taken), 32'(t));
		chk("target", s.target, r.ip + r.disp);
		chk("fetch", s.fetch_ip, t ? r.ip + r.disp : r.ip);
		chk("count", s.count, cn);
		chk("count write", 32'(s.count_wr), 32'(wr));
		if (t)
			ntaken++;
	endtask : run

	function automatic logic cc_true(input logic [3:0] cc, input bcl_flags_t f);
		logic [7:0] v;
		v = {(f.sign_flag ^ f.overflow_flag) | f.zero_flag,
			f.sign_flag ^ f.overflow_flag, f.parity_flag, f.sign_flag,
			f.carry_flag | f.zero_flag, f.zero_flag, f.carry_flag,
			f.overflow_flag};
		return v[cc[3:1]] ^ cc[0];
	endfunction : cc_true

	task automatic end_sim();
		$display("checked %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	initial begin
		#(40 * 20000);
		num_errors++;
		$display("watchdog expired");
		end_sim();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		CORE_CLK = 1'b0;
		RST = 1'b1;
		{HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
		HSIZE = 3'h2;
		{num_errors, checked, ntaken} = '0;
		r = '0;
		repeat (2) @(posedge CORE_CLK);
		RST <= 1'b0;
		@(posedge CORE_CLK);
		chk("ready", 32'(HREADYOUT), 32'h1);
		for (i = 0; i < 5; i++) begin
			bus(1'b0, 32'(i * 4), 32'h0, rd);
			chk("reset value", rd, (i == 0) ? 32'h1 : 32'h0);
		end
		$display("test reset done");
		r.ip = 32'h0000_1000;
		r.count = 32'h1234_5678;
		for (i = 0; i < 512; i++) begin
			r.cc = 4'(i / 32);
			r.flags = bcl_flags_t'(5'(i));
			r.disp = i[5] ? 32'hffff_ff80 : 32'h0000_0040;
			run(cc_true(r.cc, r.flags), r.count, 1'b0);
		end
		$display("test conditions done");
		r.op = BCL_OP_COUNT_ZERO;
		r.cc = BCL_CC_NO;
		r.flags = '1;
		for (i = 0; i < 5; i++) begin
			r.addr16 = cz_a[i];
			r.count = cz_c[i];
			run(cz_t[i], r.count, 1'b0);
		end
		$display("test count zero done");
		for (i = 0; i < 36; i++) begin
			{k, z, a, c} = {i / 12, (i / 6) % 2, (i / 3) % 2, i % 3};
			cnt = {16'h0005, 16'((c + 1) % 3)};
			r.op = bcl_op_t'(3'(k + 2));
			r.addr16 = a[0];
			r.flags = bcl_flags_t'(5'(z * 4));
			r.count = cnt;
			r.disp = 32'hffff_fff0;
			dec = a[0] ? {cnt[31:16], cnt[15:0] - 16'h1} : cnt - 32'h1;
			nz = a[0] ? (dec[15:0] != 16'h0) : (dec != 32'h0);
			et = nz & (k == 0 || (k == 1 && z[0]) || (k == 2 && !z[0]));
			run(et, dec, 1'b1);
		end
		r.op = BCL_OP_LOOP;
		r.addr16 = 1'b0;
		r.count = 32'h3;
		for (i = 0; i < 4; i++) begin
			run(i != 2, 32'(2 - i), 1'b1);
			#1;
			r.count = bcl_core_model_inst.count_q;
		end
		$display("test loops done");
		bus(1'b0, 32'(BCL_OFS_STATUS), 32'h0, rd);
		chk("status", rd, 32'h3);
		bus(1'b1, 32'(BCL_OFS_TARGET), 32'hffff_ffff, rd);
		bus(1'b0, 32'(BCL_OFS_TARGET), 32'h0, rd);
		chk("target reg", rd, r.ip + r.disp);
		bus(1'b0, 32'(BCL_OFS_TAKEN_CNT), 32'h0, rd);
		chk("taken count", rd, 32'(ntaken));
		bus(1'b1, 32'(BCL_OFS_TAKEN_CNT), 32'h0, rd);
		bus(1'b1, 32'(BCL_OFS_CTRL), 32'h0, rd);
		r.op = BCL_OP_JCC;
		r.cc = BCL_CC_E;
		bcl_core_model_inst.send(r);
		chk("refused", 32'(bcl_core_model_inst.seen_v), 32'h0);
		bus(1'b0, 32'(BCL_OFS_TAKEN_CNT), 32'h0, rd);
		chk("cleared count", rd, 32'h0);
		$display("test registers done");
		end_sim();
	end
endmodule : branch_condition_loop_unit_tb
`default_nettype wire
